// ### dv/adcr_top_asserts.sv
`timescale 1ns/10ps
module adcr_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sysref pin and chip-level controls
  input wire logic sysref_pin,
  input wire logic sample_div_reset,
  input wire logic link_drop,
  input wire logic sample_timestamp,
  input wire logic div_phase_zero,
  input wire logic [1:0] digital_downconverter_enable,
  input wire logic [4:0] decimation_ratio
);
  // ****************************************************************
  // clocking and sequences
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // pin must have been high three edges back; bench holds it longer than that
  sequence s_pin_seen;
    $past(sysref_pin, 3);
  endsequence
  sequence s_one_pulse;
    sample_div_reset ##1 !sample_div_reset;
  endsequence

  // ****************************************************************
  // sysref handling
  // ****************************************************************
  a_div_after_pin: assert property (sample_div_reset |-> s_pin_seen)
    else $error("divider reset without a sysref edge");
  a_div_single: assert property (sample_div_reset |-> s_one_pulse)
    else $error("divider reset longer than one cycle");
  a_phase_cleared: assert property (sample_div_reset |-> div_phase_zero)
    else $error("divider phase not zero at reset pulse");
  a_stamp_after_pin: assert property (sample_timestamp |-> s_pin_seen)
    else $error("timestamp without a sysref edge");
  a_mode_exclusive: assert property (!(sample_div_reset && sample_timestamp))
    else $error("divider reset and timestamp together");
  a_drop_with_reset: assert property (link_drop |-> sample_div_reset)
    else $error("link drop without divider reset");
  a_drop_phase: assert property (link_drop |-> !$past(div_phase_zero))
    else $error("link drop while divider was in phase");

  // ****************************************************************
  // mode decode
  // ****************************************************************
  a_ddc_code: assert property (digital_downconverter_enable != 2'b10)
    else $error("second downconverter on without the first");
  a_decim_ratio: assert property ($onehot(decimation_ratio))
    else $error("decimation ratio not a power of two");
endmodule // adcr_chk

bind adcr_top adcr_chk u_adcr_chk (.clk_sys(clk_sys), .rst(rst), .sysref_pin(sysref_pin),
  .sample_div_reset(sample_div_reset), .link_drop(link_drop),
  .sample_timestamp(sample_timestamp), .div_phase_zero(div_phase_zero),
  .digital_downconverter_enable(digital_downconverter_enable),
  .decimation_ratio(decimation_ratio));

// ### dv/testbench.sv
`timescale 1ns/10ps
`include "adcr_map.svh"
module testbench
  import adcr_pkg::*;
;
  logic clk_sys, rst, ce, sysref_pin;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb, flags;
  logic [1:0] bresp, rresp, ddc, rd_r, wr_r;
  logic div_rst, drop, stamp, phase0, q_en, irq, seen_div, seen_ts, seen_drop;
  logic [4:0] ratio;
  adcr_sample_type adc_sample [4];
  adcr_sample_type chan_data [4];
  int bad_count, tests_run;
  logic [9:0] idx_t [6] = '{`ADCR_IDX_SYNC, `ADCR_IDX_MODE, `ADCR_IDX_DECIM,
    `ADCR_IDX_OFFSET, `ADCR_IDX_FLAG_CTRL, `ADCR_IDX_UPPER_LO};
  logic [7:0] mask_t [6] = '{8'h01, 8'h2f, 8'h07, 8'hff, 8'h0d, 8'hff};

  adcr_top u_adcr_top (.clk_sys(clk_sys), .rst(rst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sysref_pin(sysref_pin), .adc_sample(adc_sample), .chan_data(chan_data),
    .threshold_flag_pins(flags), .sample_div_reset(div_rst), .link_drop(drop),
    .sample_timestamp(stamp), .div_phase_zero(phase0), .q_output_enable(q_en),
    .digital_downconverter_enable(ddc), .decimation_ratio(ratio), .irq(irq));

  // ****************************************************************
  // clock and verdict
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a hang counts as a mismatch and ends the run at once
  task automatic hang(string what);
    chk(what, 32'h0, 32'h1);
    complete_run();
  endtask

  // ****************************************************************
  // register bus tasks: write address and data held until both ready, read address until arready
  // ****************************************************************
  task automatic wr(logic [9:0] idx, logic [7:0] d);
    int n;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; n < 50 && !(awready && wready); n++) @(posedge clk_sys);
    if (n == 50) hang("write accept");
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk_sys);
    for (n = 0; n < 50 && !bvalid; n++) @(posedge clk_sys);
    if (n == 50) hang("write response");
    wr_r = bresp;
  endtask
  task automatic rd(logic [9:0] idx);
    int n;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; n < 50 && !arready; n++) @(posedge clk_sys);
    if (n == 50) hang("read accept");
    arvalid <= 1'b0;
    @(posedge clk_sys);
    for (n = 0; n < 50 && !rvalid; n++) @(posedge clk_sys);
    if (n == 50) hang("read response");
    rd_v = rdata;
    rd_r = rresp;
  endtask
  // sysref held 8 cycles; pulses watched for 14
  task automatic sysref_edge();
    seen_div = 1'b0;
    seen_ts = 1'b0;
    seen_drop = 1'b0;
    sysref_pin <= 1'b1;
    for (int n = 0; n < 14; n++) begin
      @(posedge clk_sys);
      seen_div |= div_rst;
      seen_ts |= stamp;
      seen_drop |= drop;
      if (n == 7) sysref_pin <= 1'b0;
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    {bready, rready} = 2'b11;
    wstrb = 4'h1;
    ce = 1'b1;
    sysref_pin = 1'b0;
    adc_sample = '{default: '0};
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // reset values, then reserved bits read zero after all-ones writes
    for (int i = 0; i < 6; i++) begin
      rd(idx_t[i]);
      chk("reset value", rd_v, 32'h0);
      wr(idx_t[i], 8'hff);
      chk("write resp", wr_r, `ADCR_RESP_OKAY);
      rd(idx_t[i]);
      chk("readback", rd_v, {24'h0, mask_t[i]});
      wr(idx_t[i], 8'h00);
    end
    rd(10'h3ff);
    chk("unmapped resp", rd_r, `ADCR_RESP_SLVERR);
    wr(10'h3ff, 8'h00);
    chk("unmapped write", wr_r, `ADCR_RESP_SLVERR);
    $display("test registers done");
    // application modes, real-only select
    for (int i = 0; i < 3; i++) begin
      wr(`ADCR_IDX_MODE, 8'(i));
      chk("ddc enable", ddc, (i == 0) ? 2'b00 : (i == 1) ? 2'b01 : 2'b11);
    end
    chk("q enable", q_en, 1'b1);
    wr(`ADCR_IDX_MODE, 8'h20);
    chk("q enable", q_en, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(`ADCR_IDX_DECIM, 8'(i));
      chk("ratio", ratio, 5'h01 << i);
    end
    $display("test modes done");
    // offset at the two range ends
    adc_sample[0] <= 14'sd100;
    wr(`ADCR_IDX_OFFSET, 8'h80);
    repeat (3) @(posedge clk_sys);
    chk("offset min", chan_data[0], 14'(-28));
    wr(`ADCR_IDX_OFFSET, 8'h7f);
    repeat (3) @(posedge clk_sys);
    chk("offset max", chan_data[0], 14'd227);
    wr(`ADCR_IDX_OFFSET, 8'h00);
    $display("test offset done");
    // forced pin both ways, then detection with interrupt
    wr(`ADCR_IDX_FLAG_CTRL, 8'h0c);
    repeat (2) @(posedge clk_sys);
    chk("forced high", flags[0], 1'b1);
    wr(`ADCR_IDX_FLAG_CTRL, 8'h08);
    repeat (2) @(posedge clk_sys);
    chk("forced low", flags[0], 1'b0);
    wr(`ADCR_IDX_IRQ_ENABLE, 8'h10);
    wr(`ADCR_IDX_UPPER_LO, 8'h10);
    wr(`ADCR_IDX_FLAG_CTRL, 8'h01);
    adc_sample[0] <= 14'sd32;
    repeat (4) @(posedge clk_sys);
    chk("detect", flags[0], 1'b1);
    chk("irq raised", irq, 1'b1);
    // four samples below the lower threshold, dwell 4, clear the pin
    wr(`ADCR_IDX_LOWER_LO, 8'h08);
    wr(`ADCR_IDX_DWELL_LO, 8'h04);
    adc_sample[0] <= 14'sd0;
    repeat (4) @(posedge clk_sys);
    chk("dwell hold", flags[0], 1'b1);
    @(posedge clk_sys);
    chk("dwell end", flags[0], 1'b0);
    adc_sample[0] <= 14'sd32;
    wr(`ADCR_IDX_FLAG_CTRL, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("detect off", flags[0], 1'b0);
    wr(`ADCR_IDX_IRQ_CLEAR, 8'hff);
    chk("irq cleared", irq, 1'b0);
    $display("test flags done");
    // sysref in both modes, divider running so a phase change can occur
    wr(`ADCR_IDX_DECIM, 8'h01);
    sysref_edge();
    chk("divider reset", {seen_div, seen_ts}, 2'b10);
    // divider restarted at phase 0 and has run 13 cycles at ratio 2: odd phase
    sysref_edge();
    chk("link drop", seen_drop, 1'b1);
    wr(`ADCR_IDX_SYNC, 8'h01);
    sysref_edge();
    chk("timestamp", {seen_div, seen_ts, seen_drop}, 3'b010);
    $display("test sysref done");
    complete_run();
  end
endmodule // testbench

// ### rtl/adcr_flag_chan.sv
`timescale 1ns/10ps
module adcr_flag_chan
  import adcr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // sample path
  input wire adcr_sample_type sample_in,
  output adcr_sample_type data_out,
  // configuration
  input wire logic [7:0] offset_adj,
  input wire logic flag_enable,
  input wire logic flag_force,
  input wire logic flag_force_val,
  input wire logic [12:0] upper_thr,
  input wire logic [12:0] lower_thr,
  input wire logic [15:0] dwell,
  // flag outputs
  output logic threshold_flag_pin,
  output logic flag_rise
);

  adcr_flag_state_type state, next_state;
  logic [15:0] below_cnt, next_below_cnt;
  logic next_flag_pin, next_flag_rise;
  adcr_sample_type next_data_out;
  logic [13:0] abs_val;
  logic [12:0] mag;
  logic signed [14:0] sum;

  // ****************************************************************
  // offset and magnitude
  // ****************************************************************
  // sum is one bit wider so the offset can saturate instead of wrapping
  always_comb begin
    sum = 15'(sample_in) + 15'($signed(offset_adj));
    if (sum > 15'sd8191) begin
      next_data_out = 14'sd8191;
    end else if (sum < -15'sd8192) begin
      next_data_out = -14'sd8192;
    end else begin
      next_data_out = sum[13:0];
    end
    abs_val = sample_in[13] ? 14'(-sample_in) : sample_in;
    // full-scale negative saturates to the largest 13-bit magnitude
    mag = abs_val[13] ? 13'h1fff : abs_val[12:0];
  end

  // ****************************************************************
  // flag state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_below_cnt = below_cnt;
    next_flag_rise = 1'b0;
    case (state)
      ADCR_FLAG_LOW: begin
        next_below_cnt = 16'h0000;
        if (flag_enable && (mag > upper_thr)) begin
          next_state = ADCR_FLAG_HIGH;
          next_flag_rise = 1'b1;
        end
      end
      ADCR_FLAG_HIGH: begin
        if (!flag_enable) begin
          next_state = ADCR_FLAG_LOW;
        end else if (mag < lower_thr) begin
          // drop once data has stayed below for the dwell count
          if (({1'b0, below_cnt} + 17'h00001) >= {1'b0, dwell}) begin
            next_state = ADCR_FLAG_LOW;
            next_below_cnt = 16'h0000;
          end else begin
            next_below_cnt = below_cnt + 16'h0001;
          end
        end else begin
          next_below_cnt = 16'h0000;
        end
      end
      default: begin
        next_state = ADCR_FLAG_LOW;
        next_below_cnt = 16'h0000;
      end
    endcase
    // forcing overrides detection on the pin only; detection keeps running
    if (flag_force) begin
      next_flag_pin = flag_force_val;
    end else begin
      next_flag_pin = (next_state == ADCR_FLAG_HIGH);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ADCR_FLAG_LOW;
      below_cnt <= 16'h0000;
      threshold_flag_pin <= 1'b0;
      flag_rise <= 1'b0;
      data_out <= 14'sd0;
    end else if (ce) begin
      state <= next_state;
      below_cnt <= next_below_cnt;
      threshold_flag_pin <= next_flag_pin;
      flag_rise <= next_flag_rise;
      data_out <= next_data_out;
    end
  end

endmodule // adcr_flag_chan

// ### rtl/adcr_map.svh
`ifndef ADCR_MAP_SVH
`define ADCR_MAP_SVH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define ADCR_IDX_SYNC 10'h1ff
`define ADCR_IDX_MODE 10'h200
`define ADCR_IDX_DECIM 10'h201
`define ADCR_IDX_OFFSET 10'h228
`define ADCR_IDX_FLAG_CTRL 10'h245
`define ADCR_IDX_UPPER_LO 10'h247
`define ADCR_IDX_UPPER_HI 10'h248
`define ADCR_IDX_LOWER_LO 10'h249
`define ADCR_IDX_LOWER_HI 10'h24a
`define ADCR_IDX_DWELL_LO 10'h24b
`define ADCR_IDX_DWELL_HI 10'h24c
`define ADCR_IDX_IRQ_STATUS 10'h300
`define ADCR_IDX_IRQ_CLEAR 10'h301
`define ADCR_IDX_IRQ_ENABLE 10'h302
`define ADCR_IDX_CHAN_SEL 10'h303
`define ADCR_IDX_LIVE 10'h304

// ****************************************************************
// field positions and write masks
// ****************************************************************
`define ADCR_SYNC_MODE_BIT 0
`define ADCR_MODE_Q_IGNORE_BIT 5
`define ADCR_MODE_WMASK 8'h20
`define ADCR_MODE_APP_MASK 8'h0f
`define ADCR_SYNC_WMASK 8'h01
`define ADCR_DECIM_WMASK 8'h07
`define ADCR_FLAG_CTRL_WMASK 8'h0d
`define ADCR_FLAG_FORCE_BIT 3
`define ADCR_FLAG_FORCE_VAL_BIT 2
`define ADCR_FLAG_ENABLE_BIT 0
`define ADCR_THR_HI_WMASK 8'h1f

// ****************************************************************
// interrupt status bit positions
// ****************************************************************
`define ADCR_IRQ_SYSREF_BIT 0
`define ADCR_IRQ_LINK_DROP_BIT 1
`define ADCR_IRQ_STAMP_BIT 2
`define ADCR_IRQ_FLAG_LSB 4

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define ADCR_RESET_BYTE 8'h00
`define ADCR_RESP_OKAY 2'b00
`define ADCR_RESP_SLVERR 2'b10

`endif

// ### rtl/adcr_pkg.sv
package adcr_pkg;

  // application mode codes
  typedef enum logic [3:0] {
    ADCR_APP_FULL_BW = 4'h0,
    ADCR_APP_ONE_DDC = 4'h1,
    ADCR_APP_TWO_DDC = 4'h2
  } adcr_app_mode_type;

  // decimation codes
  typedef enum logic [2:0] {
    ADCR_DEC_1 = 3'h0,
    ADCR_DEC_2 = 3'h1,
    ADCR_DEC_4 = 3'h2,
    ADCR_DEC_8 = 3'h3,
    ADCR_DEC_16 = 3'h4
  } adcr_decim_type;

  // fast-detect flag state
  typedef enum logic {
    ADCR_FLAG_LOW,
    ADCR_FLAG_HIGH
  } adcr_flag_state_type;

  typedef logic signed [13:0] adcr_sample_type;

endpackage

// ### rtl/adcr_top.sv
// Behaviour
// - sync mode 0: a captured sysref edge resets every internal sample divider.
// - sync mode 0: if that reset changes a divider phase, drop the link.
// - real-only bit 0 outputs I and Q; bit 1 outputs I only.
// - application mode 0000 full bandwidth, 0001 one downconverter, 0010 two.
// - decimation codes 000..100 select ratios 1, 2, 4, 8, 16.
// - each channel adds a signed 8-bit offset at converter LSB alignment.
// - force bit set drives the flag pin with the force value, else detection.
// - the force value bit appears on the flag pin while forcing.
// - enable bit turns fine fast detection off at 0, on at 1.
// - upper threshold is 13 bits, low byte in one register, versus magnitude.
// - while enabled, flag clears only after data stays below lower threshold for dwell count.
`timescale 1ns/10ps
`include "adcr_map.svh"
module adcr_top
  import adcr_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sysref pin, asynchronous
  input wire logic sysref_pin,
  // converter samples, one per channel
  input wire adcr_sample_type adc_sample [4],
  // processed data and flags
  output adcr_sample_type chan_data [4],
  output logic [3:0] threshold_flag_pins,
  // chip-level controls
  output logic sample_div_reset,
  output logic link_drop,
  output logic sample_timestamp,
  output logic div_phase_zero,
  output logic q_output_enable,
  output logic [1:0] digital_downconverter_enable,
  output logic [4:0] decimation_ratio,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic sync_mode, next_sync_mode;
  logic [7:0] mode_reg, next_mode_reg;
  logic [2:0] decim_reg, next_decim_reg;
  logic [1:0] chan_sel, next_chan_sel;
  logic [7:0] offset_reg [4];
  logic [7:0] next_offset_reg [4];
  logic [7:0] flag_ctrl [4];
  logic [7:0] next_flag_ctrl [4];
  logic [12:0] upper_thr [4];
  logic [12:0] next_upper_thr [4];
  logic [12:0] lower_thr [4];
  logic [12:0] next_lower_thr [4];
  logic [15:0] dwell [4];
  logic [15:0] next_dwell [4];
  logic [7:0] irq_status, next_irq_status;
  logic [7:0] irq_enable, next_irq_enable;

  // bus state
  logic wr_fire, rd_fire;
  logic [9:0] wr_idx, rd_idx;
  logic [7:0] wbyte;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_hit;
  logic [7:0] irq_clear;

  // chip-level timing state
  logic sync_s1, sync_s2, sync_s3, sysref_lvl, next_sysref_lvl;
  logic sysref_edge;
  logic [3:0] div_cnt, next_div_cnt;
  logic next_div_reset, next_link_drop, next_stamp;
  logic [4:0] ratio;
  logic [3:0] flag_rise;
  logic [7:0] events;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one write and one read in flight; address and data are taken together
  assign s_axi_awready = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_idx = s_axi_awaddr[11:2];
  assign rd_idx = s_axi_araddr[11:2];
  assign wbyte = s_axi_wdata[7:0];

  // write decode and register next values
  always_comb begin
    next_sync_mode = sync_mode;
    next_mode_reg = mode_reg;
    next_decim_reg = decim_reg;
    next_chan_sel = chan_sel;
    next_offset_reg = offset_reg;
    next_flag_ctrl = flag_ctrl;
    next_upper_thr = upper_thr;
    next_lower_thr = lower_thr;
    next_dwell = dwell;
    next_irq_enable = irq_enable;
    irq_clear = 8'h00;
    wr_hit = 1'b1;
    case (wr_idx)
      `ADCR_IDX_SYNC, `ADCR_IDX_MODE, `ADCR_IDX_DECIM, `ADCR_IDX_OFFSET,
      `ADCR_IDX_FLAG_CTRL, `ADCR_IDX_UPPER_LO, `ADCR_IDX_UPPER_HI,
      `ADCR_IDX_LOWER_LO, `ADCR_IDX_LOWER_HI, `ADCR_IDX_DWELL_LO,
      `ADCR_IDX_DWELL_HI, `ADCR_IDX_IRQ_STATUS, `ADCR_IDX_IRQ_CLEAR,
      `ADCR_IDX_IRQ_ENABLE, `ADCR_IDX_CHAN_SEL, `ADCR_IDX_LIVE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    // only lane 0 carries register data; masks drop reserved bits
    if (wr_fire && s_axi_wstrb[0]) begin
      case (wr_idx)
        `ADCR_IDX_SYNC: next_sync_mode = wbyte[`ADCR_SYNC_MODE_BIT];
        `ADCR_IDX_MODE: begin
          next_mode_reg = wbyte & (`ADCR_MODE_WMASK | `ADCR_MODE_APP_MASK);
        end
        `ADCR_IDX_DECIM: next_decim_reg = wbyte[2:0];
        `ADCR_IDX_OFFSET: next_offset_reg[chan_sel] = wbyte;
        `ADCR_IDX_FLAG_CTRL: begin
          next_flag_ctrl[chan_sel] = wbyte & `ADCR_FLAG_CTRL_WMASK;
        end
        `ADCR_IDX_UPPER_LO: next_upper_thr[chan_sel][7:0] = wbyte;
        `ADCR_IDX_UPPER_HI: next_upper_thr[chan_sel][12:8] = wbyte[4:0];
        `ADCR_IDX_LOWER_LO: next_lower_thr[chan_sel][7:0] = wbyte;
        `ADCR_IDX_LOWER_HI: next_lower_thr[chan_sel][12:8] = wbyte[4:0];
        `ADCR_IDX_DWELL_LO: next_dwell[chan_sel][7:0] = wbyte;
        `ADCR_IDX_DWELL_HI: next_dwell[chan_sel][15:8] = wbyte;
        `ADCR_IDX_IRQ_CLEAR: irq_clear = wbyte;
        `ADCR_IDX_IRQ_ENABLE: next_irq_enable = wbyte;
        `ADCR_IDX_CHAN_SEL: next_chan_sel = wbyte[1:0];
        default: next_sync_mode = sync_mode;
      endcase
    end
    // a new event in the clearing cycle wins over the clear
    next_irq_status = (irq_status & ~irq_clear) | events;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? `ADCR_RESP_OKAY : `ADCR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_mode <= 1'b0;
      mode_reg <= `ADCR_RESET_BYTE;
      decim_reg <= 3'h0;
      chan_sel <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        offset_reg[i] <= `ADCR_RESET_BYTE;
        flag_ctrl[i] <= `ADCR_RESET_BYTE;
        upper_thr[i] <= 13'h0000;
        lower_thr[i] <= 13'h0000;
        dwell[i] <= 16'h0000;
      end
      irq_status <= 8'h00;
      irq_enable <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCR_RESP_OKAY;
    end else if (ce) begin
      sync_mode <= next_sync_mode;
      mode_reg <= next_mode_reg;
      decim_reg <= next_decim_reg;
      chan_sel <= next_chan_sel;
      offset_reg <= next_offset_reg;
      flag_ctrl <= next_flag_ctrl;
      upper_thr <= next_upper_thr;
      lower_thr <= next_lower_thr;
      dwell <= next_dwell;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // data is registered so rvalid always comes one cycle after the address
  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = `ADCR_RESP_OKAY;
      next_rdata = 32'h00000000;
      case (rd_idx)
        `ADCR_IDX_SYNC: next_rdata[0] = sync_mode;
        `ADCR_IDX_MODE: next_rdata[7:0] = mode_reg;
        `ADCR_IDX_DECIM: next_rdata[2:0] = decim_reg;
        `ADCR_IDX_OFFSET: next_rdata[7:0] = offset_reg[chan_sel];
        `ADCR_IDX_FLAG_CTRL: next_rdata[7:0] = flag_ctrl[chan_sel];
        `ADCR_IDX_UPPER_LO: next_rdata[7:0] = upper_thr[chan_sel][7:0];
        `ADCR_IDX_UPPER_HI: next_rdata[4:0] = upper_thr[chan_sel][12:8];
        `ADCR_IDX_LOWER_LO: next_rdata[7:0] = lower_thr[chan_sel][7:0];
        `ADCR_IDX_LOWER_HI: next_rdata[4:0] = lower_thr[chan_sel][12:8];
        `ADCR_IDX_DWELL_LO: next_rdata[7:0] = dwell[chan_sel][7:0];
        `ADCR_IDX_DWELL_HI: next_rdata[7:0] = dwell[chan_sel][15:8];
        `ADCR_IDX_IRQ_STATUS: next_rdata[7:0] = irq_status;
        `ADCR_IDX_IRQ_CLEAR: next_rdata[7:0] = 8'h00; // write-only
        `ADCR_IDX_IRQ_ENABLE: next_rdata[7:0] = irq_enable;
        `ADCR_IDX_CHAN_SEL: next_rdata[1:0] = chan_sel;
        `ADCR_IDX_LIVE: next_rdata[7:0] = {div_cnt, threshold_flag_pins};
        default: next_rresp = `ADCR_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ADCR_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else if (ce) begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // sysref capture and sample divider
  // ****************************************************************
  // level changes count only when the second and third stages agree
  always_comb begin
    next_sysref_lvl = (sync_s2 == sync_s3) ? sync_s3 : sysref_lvl;
    sysref_edge = (sync_s2 == sync_s3) && sync_s3 && !sysref_lvl;
    case (decim_reg)
      ADCR_DEC_2: ratio = 5'd2;
      ADCR_DEC_4: ratio = 5'd4;
      ADCR_DEC_8: ratio = 5'd8;
      ADCR_DEC_16: ratio = 5'd16;
      default: ratio = 5'd1;
    endcase
    next_div_cnt = ({1'b0, div_cnt} + 5'd1 >= ratio) ? 4'h0 : div_cnt + 4'h1;
    next_div_reset = 1'b0;
    next_link_drop = 1'b0;
    next_stamp = 1'b0;
    if (sysref_edge) begin
      if (!sync_mode) begin
        next_div_reset = 1'b1;
        next_div_cnt = 4'h0;
        // a divider not already at phase zero would slip, so the link drops
        next_link_drop = (div_cnt != 4'h0);
      end else begin
        next_stamp = 1'b1;
      end
    end
    events = 8'h00;
    events[`ADCR_IRQ_SYSREF_BIT] = sysref_edge;
    events[`ADCR_IRQ_LINK_DROP_BIT] = next_link_drop;
    events[`ADCR_IRQ_STAMP_BIT] = next_stamp;
    events[`ADCR_IRQ_FLAG_LSB +: 4] = flag_rise;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      sysref_lvl <= 1'b0;
      div_cnt <= 4'h0;
      sample_div_reset <= 1'b0;
      link_drop <= 1'b0;
      sample_timestamp <= 1'b0;
    end else if (ce) begin
      sync_s1 <= sysref_pin;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      sysref_lvl <= next_sysref_lvl;
      div_cnt <= next_div_cnt;
      sample_div_reset <= next_div_reset;
      link_drop <= next_link_drop;
      sample_timestamp <= next_stamp;
    end
  end

  // ****************************************************************
  // chip mode decode
  // ****************************************************************
  assign div_phase_zero = (div_cnt == 4'h0);
  assign q_output_enable = !mode_reg[`ADCR_MODE_Q_IGNORE_BIT];
  assign decimation_ratio = ratio;
  assign irq = |(irq_status & irq_enable);
  // unlisted application codes fall back to full bandwidth
  always_comb begin
    case (mode_reg[3:0])
      ADCR_APP_ONE_DDC: digital_downconverter_enable = 2'b01;
      ADCR_APP_TWO_DDC: digital_downconverter_enable = 2'b11;
      default: digital_downconverter_enable = 2'b00;
    endcase
  end

  // ****************************************************************
  // per-channel offset and fast detect
  // ****************************************************************
  for (genvar c = 0; c < 4; c++) begin : g_chan
    adcr_flag_chan u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .sample_in(adc_sample[c]),
      .data_out(chan_data[c]),
      .offset_adj(offset_reg[c]),
      .flag_enable(flag_ctrl[c][`ADCR_FLAG_ENABLE_BIT]),
      .flag_force(flag_ctrl[c][`ADCR_FLAG_FORCE_BIT]),
      .flag_force_val(flag_ctrl[c][`ADCR_FLAG_FORCE_VAL_BIT]),
      .upper_thr(upper_thr[c]),
      .lower_thr(lower_thr[c]),
      .dwell(dwell[c]),
      .threshold_flag_pin(threshold_flag_pins[c]),
      .flag_rise(flag_rise[c])
    );
  end

endmodule // adcr_top
